// File: rtl/adcsq_top.sv
// Purpose: Single/scan conversion sequencer with external trigger start.
// Assumes: Software access arrives as one-cycle set/clear strobes on clk.
// Notes: Trigger pin is asynchronous and passes a three-stage filter.
`timescale 1ns/1ps
`default_nettype none
module adcsq_top import adcsq_pkg::*; #(
  parameter int NUM_CH = ADCSQ_NUM_CH,
  parameter int RES_BITS = ADCSQ_RES_BITS
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic start_set,
  input wire logic start_clear,
  input wire logic end_flag_clear,
  input wire logic scan_mode,
  input wire logic [1:0] channel_select,
  input wire logic conversion_speed_select,
  input wire logic end_interrupt_enable,
  input wire logic external_trigger_enable,
  input wire logic external_trigger_pin_n,
  input wire logic comparator_in,
  output logic conversion_start_bit,
  output logic conversion_end_flag,
  output logic conversion_end_interrupt,
  output logic [1:0] analog_channel,
  output logic sample_hold_enable,
  output logic [RES_BITS-1:0] dac_code,
  output logic result_write,
  output logic [NUM_CH*RES_BITS-1:0] result_data
);
  if (NUM_CH != ADCSQ_NUM_CH) begin : g_bad_ch
    $error("adcsq_top: channel count must be four");
  end
  if (RES_BITS != ADCSQ_RES_BITS) begin : g_bad_res
    $error("adcsq_top: resolution must be ten bits");
  end

  // Delay base per speed, used only at run start
  function automatic logic [7:0] td_base(input logic spd);
    td_base = spd ? ADCSQ_TD_MIN_S1 : ADCSQ_TD_MIN_S0;
  endfunction

  function automatic logic [7:0] spl_len(input logic spd);
    spl_len = spd ? ADCSQ_SPL_S1 : ADCSQ_SPL_S0;
  endfunction

  function automatic logic [1:0] phase_mask(input logic spd);
    phase_mask = spd ? ADCSQ_PHASE_MASK_S1 : ADCSQ_PHASE_MASK_S0;
  endfunction

  // Gap before later scan samples: scan length less sampling, approximation
  // and the one store cycle that closes each conversion
  function automatic logic [7:0] gap_len(input logic spd);
    logic [7:0] approx;
    approx = 8'h00;
    if (spd) begin
      approx = 8'(ADCSQ_BIT_S1 * 8'(RES_BITS) + ADCSQ_TAIL_S1);
      gap_len = ADCSQ_SCAN_S1 - ADCSQ_SPL_S1 - approx - 8'h01;
    end else begin
      approx = 8'(ADCSQ_BIT_S0 * 8'(RES_BITS) + ADCSQ_TAIL_S0);
      gap_len = ADCSQ_SCAN_S0 - ADCSQ_SPL_S0 - approx - 8'h01;
    end
  endfunction

  adcsq_state_t state_q;
  logic [7:0] cnt_q;
  logic [1:0] phase_q;
  // Channel pointer and last channel of the group
  logic [1:0] ch_q;
  logic [1:0] last_ch_q;
  logic scan_q;
  logic spd_q;
  logic trg_s1_q;
  logic trg_s2_q;
  logic trg_s3_q;
  logic trg_lvl_q;
  logic trg_fall;
  logic start_req;
  logic sar_go;
  logic sar_done;
  logic run_begin;
  logic store_now;
  logic [RES_BITS-1:0] sar_result;
  logic pass_end;
  logic single_end;
  logic [RES_BITS-1:0] result_q [NUM_CH];

  // Three-stage pin filter; only stage two feeds stage three
  always_ff @(posedge clk) begin
    if (srst) begin
      trg_s1_q <= 1'b1;
      trg_s2_q <= 1'b1;
      trg_s3_q <= 1'b1;
    end else if (clk_en) begin
      trg_s1_q <= external_trigger_pin_n;
      trg_s2_q <= trg_s1_q;
      trg_s3_q <= trg_s2_q;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      trg_lvl_q <= 1'b1;
    end else if (clk_en) begin
      if (trg_s2_q == trg_s3_q) begin
        trg_lvl_q <= trg_s3_q;
      end
    end
  end

  // Pin activity counts only with trigger enabled
  assign trg_fall = external_trigger_enable && trg_lvl_q
                    && (trg_s2_q == trg_s3_q) && !trg_s3_q;
  // Trigger start is the same request as a software write
  assign start_req = start_set || trg_fall;

  // Free phase of the state clock; start write timing picks delay
  always_ff @(posedge clk) begin
    if (srst) begin
      phase_q <= 2'h0;
    end else if (clk_en) begin
      phase_q <= phase_q + 2'h1;
    end
  end

  assign run_begin = (state_q == ADCSQ_IDLE) && conversion_start_bit;
  // A result counts only if the run is still on at the done pulse
  assign store_now = sar_done && (state_q == ADCSQ_CONVERT) && conversion_start_bit;
  assign pass_end = store_now && (ch_q == last_ch_q);
  assign single_end = pass_end && !scan_q;

  // Start bit: set wins over any clear in the same cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      conversion_start_bit <= 1'b0;
    end else if (clk_en) begin
      if (start_req) begin
        conversion_start_bit <= 1'b1;
      end else if (start_clear) begin
        conversion_start_bit <= 1'b0;
      end else if (single_end) begin
        conversion_start_bit <= 1'b0;
      end
    end
  end

  // Scan leaves start bit alone at pass end
  always_ff @(posedge clk) begin
    if (srst) begin
      conversion_end_flag <= 1'b0;
    end else if (clk_en) begin
      if (pass_end) begin
        conversion_end_flag <= 1'b1;
      end else if (end_flag_clear) begin
        conversion_end_flag <= 1'b0;
      end
    end
  end

  assign conversion_end_interrupt = conversion_end_flag && end_interrupt_enable;

  // Mode and speed are latched at run start; software must clear the
  // start bit before changing them
  always_ff @(posedge clk) begin
    if (srst) begin
      scan_q <= 1'b0;
      spd_q <= 1'b0;
    end else if (clk_en) begin
      if (run_begin) begin
        scan_q <= scan_mode;
        spd_q <= conversion_speed_select;
      end
    end
  end

  // Channel pointer: single holds the selected channel, scan walks the group
  always_ff @(posedge clk) begin
    if (srst) begin
      ch_q <= 2'h0;
      last_ch_q <= 2'h0;
    end else if (clk_en) begin
      if (run_begin) begin
        last_ch_q <= channel_select;
        if (scan_mode) begin
          ch_q <= 2'h0;
        end else begin
          ch_q <= channel_select;
        end
      end else if (store_now && scan_q) begin
        if (ch_q == last_ch_q) begin
          ch_q <= 2'h0;
        end else begin
          ch_q <= ch_q + 2'h1;
        end
      end
    end
  end

  // Sequencer state; unused encodings fall back to idle
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= ADCSQ_IDLE;
    end else if (clk_en) begin
      unique case (state_q)
        ADCSQ_IDLE: begin
          if (conversion_start_bit) begin
            state_q <= ADCSQ_DELAY;
          end
        end
        ADCSQ_DELAY: begin
          if (!conversion_start_bit) begin
            state_q <= ADCSQ_IDLE;
          end else if (cnt_q == 8'h00) begin
            state_q <= ADCSQ_SAMPLE;
          end
        end
        ADCSQ_SAMPLE: begin
          if (!conversion_start_bit) begin
            state_q <= ADCSQ_IDLE;
          end else if (cnt_q == 8'h00) begin
            state_q <= ADCSQ_CONVERT;
          end
        end
        ADCSQ_CONVERT: begin
          if (!conversion_start_bit) begin
            state_q <= ADCSQ_IDLE;
          end else if (sar_done) begin
            if (!scan_q) begin
              state_q <= ADCSQ_IDLE;
            end else if (gap_len(spd_q) == 8'h00) begin
              // Fast scan has no gap: the next sample follows the store
              state_q <= ADCSQ_SAMPLE;
            end else begin
              state_q <= ADCSQ_GAP;
            end
          end
        end
        ADCSQ_GAP: begin
          if (!conversion_start_bit) begin
            state_q <= ADCSQ_IDLE;
          end else if (cnt_q == 8'h00) begin
            state_q <= ADCSQ_SAMPLE;
          end
        end
        default: begin
          state_q <= ADCSQ_IDLE;
        end
      endcase
    end
  end

  // State counter, loaded with one less than the length of the next state
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_q <= 8'h00;
    end else if (clk_en) begin
      unique case (state_q)
        ADCSQ_IDLE: begin
          if (conversion_start_bit) begin
            // Cycle of the start counts as the first delay state
            cnt_q <= td_base(conversion_speed_select)
                     + {6'h00, phase_q & phase_mask(conversion_speed_select)}
                     - 8'h02;
          end
        end
        ADCSQ_DELAY, ADCSQ_GAP: begin
          if (cnt_q == 8'h00) begin
            cnt_q <= spl_len(spd_q) - 8'h01;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        ADCSQ_SAMPLE: begin
          if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        ADCSQ_CONVERT: begin
          if (sar_done) begin
            // Later passes use the fixed length
            if (gap_len(spd_q) == 8'h00) begin
              cnt_q <= spl_len(spd_q) - 8'h01;
            end else begin
              cnt_q <= gap_len(spd_q) - 8'h01;
            end
          end
        end
        default: begin
          cnt_q <= 8'h00;
        end
      endcase
    end
  end

  // Approximation starts on the last sample state
  assign sar_go = clk_en && (state_q == ADCSQ_SAMPLE) && (cnt_q == 8'h00)
                  && conversion_start_bit;

  assign analog_channel = ch_q;
  assign sample_hold_enable = (state_q == ADCSQ_SAMPLE);

  // Held in reset while idle, so a stopped run leaves no half-built code
  adcsq_sar #(
    .RES_BITS(RES_BITS)
  ) u_sar (
    .clk(clk),
    .srst(srst || (state_q == ADCSQ_IDLE)),
    .clk_en(clk_en),
    .go(sar_go),
    .speed_select(spd_q),
    .comparator_in(comparator_in),
    .dac_code(dac_code),
    .busy(),
    .done(sar_done),
    .result(sar_result)
  );

  // One data register per channel; hazard: a stopped run leaves old data
  for (genvar gi = 0; gi < NUM_CH; gi++) begin : g_res
    always_ff @(posedge clk) begin
      if (srst) begin
        result_q[gi] <= ADCSQ_RESULT_RST;
      end else if (clk_en) begin
        // Channel pointer still names the finished channel here
        if (store_now && (ch_q == 2'(gi))) begin
          result_q[gi] <= sar_result;
        end
      end
    end
    assign result_data[gi*RES_BITS +: RES_BITS] = result_q[gi];
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      result_write <= 1'b0;
    end else if (clk_en) begin
      result_write <= store_now;
    end
  end
endmodule
`default_nettype wire

// File: rtl/adcsq_pkg.sv
// Purpose: Constants for the converter scan/trigger sequencer.
// Assumes: One state is one clk cycle of the 250 MHz system clock.
// Notes: Counts are in states, as the converter timing is specified.
// How it works
// - Scan starts on channel 0 once start bit is set by software or trigger.
// - Each finished channel's result lands in that channel's own data register.
// - After the whole group, set end flag; interrupt if end enable set.
// - After the last channel, restart at the first channel unprompted.
// - Scan keeps start bit set and repeats while it stays one.
// - Clearing the start bit during scanning stops conversion.
// - Start delay, then sample-and-hold, then successive approximation.
// - Start delay is 6 to 9 states (speed 0) or 4 to 5 (speed 1).
// - Conversion time includes delay and sampling: 31 or 15 states.
// - Single conversion takes 131..134 states (speed 0) or 69..70 (speed 1).
// - Start delay varies with the timing of the start write.
// - Later scan conversions take fixed 128 or 66 states.
// - Trigger pin is ignored unless external trigger enable is one.
// - Enabled trigger falling edge sets start bit; source must make that edge.
// - Triggered conversion behaves exactly like a software start.
// - Result is 10-bit unsigned, zero at minimum, all ones at full scale.
// - Single mode converts once, clears start bit, returns to idle.
package adcsq_pkg;
  localparam int ADCSQ_RES_BITS = 10;
  localparam int ADCSQ_NUM_CH = 4;
  localparam int ADCSQ_CNT_W = 8;
  // Start delay: base plus write phase
  localparam logic [7:0] ADCSQ_TD_MIN_S0 = 8'h06;
  localparam logic [7:0] ADCSQ_TD_MAX_S0 = 8'h09;
  localparam logic [7:0] ADCSQ_TD_MIN_S1 = 8'h04;
  localparam logic [7:0] ADCSQ_TD_MAX_S1 = 8'h05;
  // Sampling period
  localparam logic [7:0] ADCSQ_SPL_S0 = 8'h1F;
  localparam logic [7:0] ADCSQ_SPL_S1 = 8'h0F;
  // Approximation: states per bit and closing tail
  localparam logic [7:0] ADCSQ_BIT_S0 = 8'h09;
  localparam logic [7:0] ADCSQ_TAIL_S0 = 8'h04;
  localparam logic [7:0] ADCSQ_BIT_S1 = 8'h05;
  localparam logic [7:0] ADCSQ_TAIL_S1 = 8'h00;
  // Whole conversion lengths
  localparam logic [7:0] ADCSQ_SCAN_S0 = 8'h80;
  localparam logic [7:0] ADCSQ_SCAN_S1 = 8'h42;
  localparam logic [1:0] ADCSQ_PHASE_MASK_S0 = 2'h3;
  localparam logic [1:0] ADCSQ_PHASE_MASK_S1 = 2'h1;
  localparam logic [9:0] ADCSQ_RESULT_RST = 10'h000;
  typedef enum logic [2:0] {
    ADCSQ_IDLE,
    ADCSQ_DELAY,
    ADCSQ_SAMPLE,
    ADCSQ_CONVERT,
    ADCSQ_GAP
  } adcsq_state_t;
endpackage

// File: rtl/adcsq_sar.sv
// Purpose: Successive-approximation register for the converter.
// Assumes: Comparator output is settled logic on clk.
// Notes: Busy for 10 bit slots plus a tail after go; speed 1 has no tail.
`timescale 1ns/1ps
`default_nettype none
module adcsq_sar import adcsq_pkg::*; #(
  parameter int RES_BITS = ADCSQ_RES_BITS
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic go,
  input wire logic speed_select,
  input wire logic comparator_in,
  output logic [RES_BITS-1:0] dac_code,
  output logic busy,
  output logic done,
  output logic [RES_BITS-1:0] result
);
  logic [7:0] cnt_q;
  logic [3:0] bit_q;
  logic tail_q;
  logic [7:0] slot_len;
  logic [7:0] tail_len;

  assign slot_len = speed_select ? ADCSQ_BIT_S1 : ADCSQ_BIT_S0;
  assign tail_len = speed_select ? ADCSQ_TAIL_S1 : ADCSQ_TAIL_S0;
  assign result = dac_code;

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_q <= 8'h00;
      bit_q <= 4'h0;
      tail_q <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      dac_code <= '0;
    end else if (clk_en) begin
      done <= 1'b0;
      if (go) begin
        busy <= 1'b1;
        tail_q <= 1'b0;
        cnt_q <= 8'h01;
        bit_q <= 4'(RES_BITS - 1);
        dac_code <= '0;
        dac_code[RES_BITS-1] <= 1'b1;
      end else if (busy && !tail_q) begin
        if (cnt_q == slot_len) begin
          // Keep trial bit only while input is above the DAC level
          dac_code[bit_q] <= comparator_in;
          cnt_q <= 8'h01;
          if (bit_q == 4'h0) begin
            tail_q <= 1'b1;
            if (tail_len == 8'h00) begin
              busy <= 1'b0;
              done <= 1'b1;
            end
          end else begin
            bit_q <= bit_q - 4'h1;
            dac_code[bit_q - 4'h1] <= 1'b1;
          end
        end else begin
          cnt_q <= cnt_q + 8'h01;
        end
      end else if (busy) begin
        if (cnt_q == tail_len) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 8'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: verif/adcsq_top_chk_sva.sv
// Purpose: Port-level timing checks for the scan/trigger sequencer.
// Assumes: clk_en held high; software keeps mode and speed steady in a run.
// Notes: Sampling length is counted in helper logic, not by repetition.
`timescale 1ns/1ps
`default_nettype none
module adcsq_top_chk (
  input wire logic clk,
  input wire logic srst,
  input wire logic start_set,
  input wire logic start_clear,
  input wire logic end_flag_clear,
  input wire logic scan_mode,
  input wire logic conversion_speed_select,
  input wire logic end_interrupt_enable,
  input wire logic external_trigger_enable,
  input wire logic conversion_start_bit,
  input wire logic conversion_end_flag,
  input wire logic conversion_end_interrupt,
  input wire logic sample_hold_enable,
  input wire logic result_write
);
  logic [7:0] sh_cnt_q;
  always_ff @(posedge clk) begin
    if (srst || !sample_hold_enable) begin
      sh_cnt_q <= 8'h00;
    end else begin
      sh_cnt_q <= sh_cnt_q + 8'h01;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  property p_irq;
    conversion_end_interrupt == (conversion_end_flag && end_interrupt_enable);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt differs from flag and enable");
  property p_take;
    start_set |=> conversion_start_bit;
  endproperty
  a_take: assert property (p_take) else $error("start request not taken");
  property p_stop;
    start_clear && !start_set |=> !conversion_start_bit ##1 !sample_hold_enable;
  endproperty
  a_stop: assert property (p_stop) else $error("clear did not stop conversion");
  property p_sticky;
    conversion_end_flag && !end_flag_clear |=> conversion_end_flag;
  endproperty
  a_sticky: assert property (p_sticky) else $error("end flag dropped by itself");
  property p_single;
    result_write && !$past(scan_mode) |-> conversion_end_flag && !conversion_start_bit;
  endproperty
  a_single: assert property (p_single) else $error("single end state wrong");
  property p_keep;
    result_write && $past(scan_mode) && !$past(start_clear) |-> conversion_start_bit;
  endproperty
  a_keep: assert property (p_keep) else $error("scan dropped start bit");
  property p_dly0;
    $rose(conversion_start_bit) && !conversion_speed_select
      |-> !sample_hold_enable [*6] ##[1:4] sample_hold_enable;
  endproperty
  a_dly0: assert property (p_dly0) else $error("slow start delay out of range");
  property p_dly1;
    $rose(conversion_start_bit) && conversion_speed_select
      |-> !sample_hold_enable [*4] ##[1:2] sample_hold_enable;
  endproperty
  a_dly1: assert property (p_dly1) else $error("fast start delay out of range");
  property p_spl;
    $fell(sample_hold_enable) && conversion_start_bit
      |-> sh_cnt_q == (conversion_speed_select ? 8'h0F : 8'h1F);
  endproperty
  a_spl: assert property (p_spl) else $error("sampling length wrong");
  property p_trig_off;
    !external_trigger_enable && !start_set && !conversion_start_bit |=> !conversion_start_bit;
  endproperty
  a_trig_off: assert property (p_trig_off) else $error("start without request");
  c_single: cover property (result_write && !scan_mode);
  c_scan_end: cover property (result_write && scan_mode && conversion_end_flag);
  c_stop: cover property (start_clear && conversion_start_bit);
  c_trig: cover property ($rose(conversion_start_bit) && external_trigger_enable);
endmodule
bind adcsq_top adcsq_top_chk u_chk (
  .clk(clk), .srst(srst), .start_set(start_set), .start_clear(start_clear),
  .end_flag_clear(end_flag_clear), .scan_mode(scan_mode),
  .conversion_speed_select(conversion_speed_select),
  .end_interrupt_enable(end_interrupt_enable),
  .external_trigger_enable(external_trigger_enable),
  .conversion_start_bit(conversion_start_bit), .conversion_end_flag(conversion_end_flag),
  .conversion_end_interrupt(conversion_end_interrupt),
  .sample_hold_enable(sample_hold_enable), .result_write(result_write)
);
`default_nettype wire

// File: verif/adcsq_far_model.sv
// Purpose: Analog inputs with comparator, and an external trigger source.
// Assumes: Each input sits half a step above its code, so equal reads above.
// Notes: Trigger pulse is six cycles low, wide enough for the pin filter.
`timescale 1ns/1ps
`default_nettype none
module adcsq_far_model #(
  parameter logic [39:0] LEVELS = 40'h0000000000
) (
  input wire logic clk,
  input wire logic [1:0] analog_channel,
  input wire logic [9:0] dac_code,
  input wire logic trig_go,
  output logic comparator_in,
  output logic external_trigger_pin_n
);
  logic [2:0] low_q = 3'h0;
  assign comparator_in = LEVELS[analog_channel*10 +: 10] >= dac_code;
  always_ff @(posedge clk) begin
    if (trig_go) begin
      low_q <= 3'h6;
    end else if (low_q != 3'h0) begin
      low_q <= low_q - 3'h1;
    end
  end
  assign external_trigger_pin_n = (low_q == 3'h0);
endmodule
`default_nettype wire

// File: verif/tb_top.sv
// Purpose: Directed single, scan, stop and trigger runs with timing checks.
// Assumes: Inputs change on falling clk; clk_en held high throughout.
// Notes: Every wait is bounded; a hang ends the run as a failure.
`timescale 1ns/1ps
`default_nettype none
module tb_top import adcsq_pkg::*;;
  localparam logic [39:0] LEVELS = 40'hAA955FFC00;
  logic clk, srst, sset, sclr, fclr, scan, spd, iena, tena, trig_go;
  logic [1:0] chsel, ach;
  logic [9:0] dac;
  logic cmp, pin_n, sbit, eflag, eirq, she, rwr;
  logic [39:0] rdata;
  int bad_count, cmp_count, n;
  adcsq_top uut (.clk(clk), .srst(srst), .clk_en(1'b1), .start_set(sset), .start_clear(sclr),
    .end_flag_clear(fclr), .scan_mode(scan), .channel_select(chsel),
    .conversion_speed_select(spd), .end_interrupt_enable(iena),
    .external_trigger_enable(tena), .external_trigger_pin_n(pin_n), .comparator_in(cmp),
    .conversion_start_bit(sbit), .conversion_end_flag(eflag), .conversion_end_interrupt(eirq),
    .analog_channel(ach), .sample_hold_enable(she), .dac_code(dac), .result_write(rwr),
    .result_data(rdata));
  adcsq_far_model #(.LEVELS(LEVELS)) far (.clk(clk), .analog_channel(ach), .dac_code(dac),
    .trig_go(trig_go), .comparator_in(cmp), .external_trigger_pin_n(pin_n));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Counts falling edges until sampling (pick 1) or a result store (pick 0)
  task automatic wait_for(input logic pick);
    n = 0;
    do begin
      @(negedge clk);
      n++;
      if (n > 300) begin
        chk("wait bound", 1'b0, 1'b1);
        print_verdict();
      end
    end while ((pick ? she : rwr) !== 1'b1);
  endtask
  task automatic quiet(input string what);
    int hits;
    hits = 0;
    repeat (40) begin
      @(negedge clk);
      hits += (sbit === 1'b1 || rwr === 1'b1);
    end
    chk(what, 0, hits);
  endtask
  task automatic pulse_start();
    fclr = 1'b1;
    @(negedge clk);
    fclr = 1'b0;
    sset = 1'b1;
    @(negedge clk);
    sset = 1'b0;
  endtask
  task automatic finish_single(input logic sp, input int ch);
    wait_for(1'b0);
    chk("single time", 1, (n - 1 >= (sp ? 69 : 131)) && (n - 1 <= (sp ? 70 : 134)));
    chk("single result", LEVELS[ch*10 +: 10], rdata[ch*10 +: 10]);
    chk("single start bit", 0, sbit);
    chk("single irq", iena, eirq);
  endtask
  task automatic scan_run(input logic sp, input int cs);
    int t;
    scan = 1'b1;
    spd = sp;
    chsel = cs[1:0];
    iena = 1'b1;
    pulse_start();
    for (int i = 0; i < 2 * (cs + 1) + 1; i++) begin
      wait_for(1'b1);
      t = n;
      chk("scan channel", i % (cs + 1), ach);
      wait_for(1'b0);
      t += n;
      if (i == 0) begin
        chk("scan first", 1, (t - 1 >= (sp ? 69 : 131)) && (t - 1 <= (sp ? 70 : 134)));
      end else begin
        chk("scan period", sp ? ADCSQ_SCAN_S1 : ADCSQ_SCAN_S0, t);
      end
      chk("scan result", LEVELS[(i%(cs+1))*10 +: 10], rdata[(i%(cs+1))*10 +: 10]);
      chk("scan end flag", i >= cs, eflag);
      chk("scan irq", i >= cs, eirq);
      chk("scan start bit", 1, sbit);
    end
    wait_for(1'b1);
    sclr = 1'b1;
    @(negedge clk);
    sclr = 1'b0;
    quiet("scan stopped");
  endtask
  initial begin
    {srst, sset, sclr, fclr, scan, spd, iena, tena, trig_go} = 9'h100;
    chsel = 2'h0;
    bad_count = 0;
    cmp_count = 0;
    repeat (6) @(negedge clk);
    srst = 1'b0;
    chk("reset start bit", 0, sbit);
    chk("reset flag", 0, eflag);
    chk("reset results", 0, rdata);
    for (int s = 0; s < 2; s++) begin
      for (int c = 0; c < 4; c++) begin
        spd = s[0];
        chsel = c[1:0];
        iena = c[0];
        pulse_start();
        finish_single(s[0], c);
      end
    end
    scan_run(1'b0, 3);
    scan_run(1'b1, 1);
    scan = 1'b0;
    spd = 1'b0;
    chsel = 2'h2;
    trig_go = 1'b1;
    @(negedge clk);
    trig_go = 1'b0;
    quiet("trigger disabled");
    tena = 1'b1;
    fclr = 1'b1;
    trig_go = 1'b1;
    @(negedge clk);
    fclr = 1'b0;
    trig_go = 1'b0;
    // Start bit rises four edges after the pin falls
    repeat (4) @(negedge clk);
    chk("trigger start bit", 1, sbit);
    finish_single(1'b0, 2);
    print_verdict();
  end
endmodule
`default_nettype wire
